// File: core/chan_one_config_cal_regs.v
/*
 * Channel one configuration and calibration register bank, Wishbone slave.
 * Holds the configuration word, offset and gain calibration halves, and a
 * global DC-block code, and presents them as registered channel controls.
 * Assumes a classic Wishbone master on I_CLK, 32-bit data, byte addresses with bits 1:0 zero.
 * Assumes the master holds each request until ack or err and then drops
 * cyc and stb for at least one cycle; writes land on the ack edge.
 * Assumes I_RST_N is asynchronous, active low, and released on a clock edge.
 * Consumers of the outputs sit in the same clock domain.
 */
// Function
// - Config register at Eh, resets zero
// - Bits 15:6 signed ten-bit phase delay
// - Bit 2 disables DC block for channel
// - Select 00 pins, 01 shorted inputs
// - Select 10 positive, 11 negative test
// - Fh holds offset bits 23:8
// - 10h bits 15:8 hold offset 7:0
// - Lower registers bits 7:0 read zero
// - 11h gain bits 23:8, reset 8000h
// - 12h bits 15:8 hold gain 7:0
// - Global code 0000b disables DC blocking
`timescale 1ns/1ps
`include "chan_one_regs.vh"
module chan_one_config_cal_regs (
    // Clock and reset
    input  wire        I_CLK,
    input  wire        I_RST_N,
    // Wishbone slave
    input  wire        I_WB_CYC,
    input  wire        I_WB_STB,
    input  wire        I_WB_WE,
    input  wire [7:0]  I_WB_ADR,
    input  wire [3:0]  I_WB_SEL,
    input  wire [31:0] I_WB_DAT,
    output reg  [31:0] O_WB_DAT,
    output reg         O_WB_ACK,
    output reg         O_WB_ERR,
    // Channel controls
    output reg  [9:0]  O_CHAN_ONE_PHASE_DELAY,
    output reg         O_CHAN_ONE_DC_BLOCK_OFF,
    output reg  [1:0]  O_CHAN_ONE_INPUT_SELECT,
    output reg         O_SEL_PINS,
    output reg         O_SEL_SHORTED,
    output reg         O_SEL_TEST_POS,
    output reg         O_SEL_TEST_NEG,
    output reg  [23:0] O_CHAN_ONE_OFFSET,
    output reg  [23:0] O_CHAN_ONE_GAIN,
    output wire [3:0]  O_DC_FILTER_CODE,
    output wire        O_DC_FILTER_ON
);
    // ****************************************************************
    // Address decode
    // ****************************************************************
    function is_index;
        input [7:0] adr;
        input [4:0] idx;
        begin
            is_index = (adr[1:0] == 2'h0) && (adr[7:2] == {1'b0, idx});
        end
    endfunction

    wire        req;
    wire        wr;
    wire        hit_cfg;
    wire        hit_ou;
    wire        hit_ol;
    wire        hit_gu;
    wire        hit_gl;
    wire        hit_gdc;
    wire        hit_any;
    wire [15:0] config_q;
    wire [15:0] off_up_q;
    wire [15:0] off_lo_q;
    wire [15:0] gain_up_q;
    wire [15:0] gain_lo_q;
    wire [15:0] gdc_q;
    reg  [31:0] next_rdata;

    assign req     = I_WB_CYC && I_WB_STB && !O_WB_ACK && !O_WB_ERR;
    assign hit_cfg = is_index(I_WB_ADR, `IDX_CONFIG);
    assign hit_ou  = is_index(I_WB_ADR, `IDX_OFFSET_UPPER);
    assign hit_ol  = is_index(I_WB_ADR, `IDX_OFFSET_LOWER);
    assign hit_gu  = is_index(I_WB_ADR, `IDX_GAIN_UPPER);
    assign hit_gl  = is_index(I_WB_ADR, `IDX_GAIN_LOWER);
    assign hit_gdc = is_index(I_WB_ADR, `IDX_GLOBAL_DC);
    assign hit_any = hit_cfg | hit_ou | hit_ol | hit_gu | hit_gl | hit_gdc;
    assign wr      = I_WB_CYC && I_WB_STB && I_WB_WE && O_WB_ACK && hit_any;

    // ****************************************************************
    // Per-register strobes; a write lands on the ack edge
    // ****************************************************************
    wire        rd_take;
    wire        err_take;
    wire        we_cfg;
    wire        we_ou;
    wire        we_ol;
    wire        we_gu;
    wire        we_gl;
    wire        we_gdc;

    assign rd_take  = req && !I_WB_WE && hit_any;
    assign err_take = req && !hit_any;
    assign we_cfg   = wr && hit_cfg;
    assign we_ou    = wr && hit_ou;
    assign we_ol    = wr && hit_ol;
    assign we_gu    = wr && hit_gu;
    assign we_gl    = wr && hit_gl;
    assign we_gdc   = wr && hit_gdc;

    // ****************************************************************
    // Register storage
    // ****************************************************************
    masked_reg16 #(
        .RESET_VALUE (`RST_CONFIG),
        .WRITE_MASK  (`CFG_WRITE_MASK)
    ) u_config (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_we    (we_cfg),
        .i_sel   (I_WB_SEL[1:0]),
        .i_wdata (I_WB_DAT[15:0]),
        .o_value (config_q)
    );

    masked_reg16 #(
        .RESET_VALUE (`RST_OFFSET_UPPER),
        .WRITE_MASK  (16'hFFFF)
    ) u_off_up (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_we    (we_ou),
        .i_sel   (I_WB_SEL[1:0]),
        .i_wdata (I_WB_DAT[15:0]),
        .o_value (off_up_q)
    );

    masked_reg16 #(
        .RESET_VALUE (`RST_OFFSET_LOWER),
        .WRITE_MASK  (`LOWER_WRITE_MASK)
    ) u_off_lo (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_we    (we_ol),
        .i_sel   (I_WB_SEL[1:0]),
        .i_wdata (I_WB_DAT[15:0]),
        .o_value (off_lo_q)
    );

    masked_reg16 #(
        .RESET_VALUE (`RST_GAIN_UPPER),
        .WRITE_MASK  (16'hFFFF)
    ) u_gain_up (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_we    (we_gu),
        .i_sel   (I_WB_SEL[1:0]),
        .i_wdata (I_WB_DAT[15:0]),
        .o_value (gain_up_q)
    );

    masked_reg16 #(
        .RESET_VALUE (`RST_GAIN_LOWER),
        .WRITE_MASK  (`LOWER_WRITE_MASK)
    ) u_gain_lo (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_we    (we_gl),
        .i_sel   (I_WB_SEL[1:0]),
        .i_wdata (I_WB_DAT[15:0]),
        .o_value (gain_lo_q)
    );

    masked_reg16 #(
        .RESET_VALUE ({12'h000, `RST_GLOBAL_DC}),
        .WRITE_MASK  (`GLOBAL_DC_MASK)
    ) u_global_dc (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_we    (we_gdc),
        .i_sel   (I_WB_SEL[1:0]),
        .i_wdata (I_WB_DAT[15:0]),
        .o_value (gdc_q)
    );

    // ****************************************************************
    // Effective DC-block setting
    // ****************************************************************
    dc_block_select u_dc (
        .i_clk         (I_CLK),
        .i_rst_n       (I_RST_N),
        .i_global_code (gdc_q[3:0]),
        .i_chan_off    (config_q[`CFG_DC_OFF_BIT]),
        .o_code        (O_DC_FILTER_CODE),
        .o_enabled     (O_DC_FILTER_ON)
    );

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always @* begin
        next_rdata = 32'h0000_0000;
        case (1'b1)
            hit_cfg: next_rdata = {16'h0000, config_q};
            hit_ou:  next_rdata = {16'h0000, off_up_q};
            hit_ol:  next_rdata = {16'h0000, off_lo_q};
            hit_gu:  next_rdata = {16'h0000, gain_up_q};
            hit_gl:  next_rdata = {16'h0000, gain_lo_q};
            hit_gdc: next_rdata = {16'h0000, gdc_q};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Bus answer: one cycle after request, unmapped gets err
    // ****************************************************************
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_WB_ACK <= 1'b0;
            O_WB_ERR <= 1'b0;
        end else begin
            O_WB_ACK <= req && hit_any;
            O_WB_ERR <= err_take;
        end
    end

    // Read data stands until the next read
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_WB_DAT <= 32'h0000_0000;
        end else if (rd_take) begin
            O_WB_DAT <= next_rdata;
        end
    end

    // ****************************************************************
    // Field views of the stored words
    // ****************************************************************
    wire [9:0]  phase_field;
    wire        dc_off_field;
    wire [1:0]  sel_field;
    wire [23:0] offset_word;
    wire [23:0] gain_word;

    assign phase_field  = config_q[`CFG_PHASE_HI:`CFG_PHASE_LO];
    assign dc_off_field = config_q[`CFG_DC_OFF_BIT];
    assign sel_field    = config_q[`CFG_SEL_HI:`CFG_SEL_LO];
    assign offset_word  = {off_up_q, off_lo_q[`LOWER_FIELD_HI:`LOWER_FIELD_LO]};
    assign gain_word    = {gain_up_q, gain_lo_q[`LOWER_FIELD_HI:`LOWER_FIELD_LO]};

    // ****************************************************************
    // Configuration outputs
    // ****************************************************************
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_CHAN_ONE_PHASE_DELAY  <= `RST_PHASE;
            O_CHAN_ONE_DC_BLOCK_OFF <= 1'b0;
            O_CHAN_ONE_INPUT_SELECT <= `SEL_PINS;
        end else begin
            O_CHAN_ONE_PHASE_DELAY  <= phase_field;
            O_CHAN_ONE_DC_BLOCK_OFF <= dc_off_field;
            O_CHAN_ONE_INPUT_SELECT <= sel_field;
        end
    end

    // ****************************************************************
    // Input select decode, one line per source
    // ****************************************************************
    function sel_is;
        input [1:0] sel;
        input [1:0] code;
        begin
            sel_is = (sel == code);
        end
    endfunction

    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_SEL_PINS     <= 1'b1;
            O_SEL_SHORTED  <= 1'b0;
            O_SEL_TEST_POS <= 1'b0;
            O_SEL_TEST_NEG <= 1'b0;
        end else begin
            O_SEL_PINS     <= sel_is(sel_field, `SEL_PINS);
            O_SEL_SHORTED  <= sel_is(sel_field, `SEL_SHORTED);
            O_SEL_TEST_POS <= sel_is(sel_field, `SEL_TEST_POS);
            O_SEL_TEST_NEG <= sel_is(sel_field, `SEL_TEST_NEG);
        end
    end

    // ****************************************************************
    // Calibration words, upper half above the lower field
    // ****************************************************************
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_CHAN_ONE_OFFSET <= {`RST_OFFSET_UPPER, `RST_LOWER_FIELD};
            O_CHAN_ONE_GAIN   <= {`RST_GAIN_UPPER, `RST_LOWER_FIELD};
        end else begin
            O_CHAN_ONE_OFFSET <= offset_word;
            O_CHAN_ONE_GAIN   <= gain_word;
        end
    end
endmodule

// File: core/chan_one_regs.vh
/*
 * Register map constants for the channel one configuration and calibration bank.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef CHAN_ONE_REGS_VH
`define CHAN_ONE_REGS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_CONFIG          5'h0E
`define IDX_OFFSET_UPPER    5'h0F
`define IDX_OFFSET_LOWER    5'h10
`define IDX_GAIN_UPPER      5'h11
`define IDX_GAIN_LOWER      5'h12
`define IDX_GLOBAL_DC       5'h03

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CONFIG          16'h0000
`define RST_OFFSET_UPPER    16'h0000
`define RST_OFFSET_LOWER    16'h0000
`define RST_GAIN_UPPER      16'h8000
`define RST_GAIN_LOWER      16'h0000
`define RST_GLOBAL_DC       4'h0
`define RST_PHASE           10'h000
`define RST_LOWER_FIELD     8'h00

// ****************************************************************
// Field layout
// ****************************************************************
`define CFG_PHASE_HI        15
`define CFG_PHASE_LO        6
`define CFG_DC_OFF_BIT      2
`define CFG_SEL_HI          1
`define CFG_SEL_LO          0
`define LOWER_FIELD_HI      15
`define LOWER_FIELD_LO      8
`define CFG_WRITE_MASK      16'hFFC7
`define LOWER_WRITE_MASK    16'hFF00
`define GLOBAL_DC_MASK      16'h000F

// ****************************************************************
// Input select codes and DC-block codes
// ****************************************************************
`define SEL_PINS            2'h0
`define SEL_SHORTED         2'h1
`define SEL_TEST_POS        2'h2
`define SEL_TEST_NEG        2'h3
`define DC_COEFF_OFF        4'h0

`endif

// File: core/dc_block_select.v
/*
 * Resolves the effective DC-block coefficient code for channel one.
 * Assumes the global code and channel disable bit are register outputs.
 */
`timescale 1ns/1ps
`include "chan_one_regs.vh"
module dc_block_select (
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_rst_n,
    // Settings
    input  wire [3:0] i_global_code,
    input  wire       i_chan_off,
    // Result
    output reg  [3:0] o_code,
    output reg        o_enabled
);
    // ****************************************************************
    // Channel disable overrides, global 0000b turns all blocking off
    // ****************************************************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_code    <= `DC_COEFF_OFF;
            o_enabled <= 1'b0;
        end else if (i_chan_off) begin
            o_code    <= `DC_COEFF_OFF;
            o_enabled <= 1'b0;
        end else begin
            o_code    <= i_global_code;
            o_enabled <= (i_global_code != `DC_COEFF_OFF);
        end
    end
endmodule

// File: core/masked_reg16.v
/*
 * 16-bit register with per-bit write mask and Wishbone byte lanes.
 * Assumes a write strobe qualified by the bus slave.
 */
`timescale 1ns/1ps
module masked_reg16 #(
    parameter [15:0] RESET_VALUE = 16'h0000,
    parameter [15:0] WRITE_MASK  = 16'hFFFF
) (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst_n,
    // Write port
    input  wire        i_we,
    input  wire [1:0]  i_sel,
    input  wire [15:0] i_wdata,
    // State
    output reg  [15:0] o_value
);
    wire [15:0] lane_mask;
    assign lane_mask = {{8{i_sel[1]}}, {8{i_sel[0]}}} & WRITE_MASK;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_value <= RESET_VALUE;
        end else if (i_we) begin
            o_value <= (o_value & ~lane_mask) | (i_wdata & lane_mask);
        end
    end
endmodule

// File: sim/chan_one_config_cal_regs_tb_top.sv
/* Self-checking bench for the channel one register bank.
   Assumes the bank answers each Wishbone request with ack or err. */
`timescale 1ns/1ps
module chan_one_config_cal_regs_tb_top;
    logic        clk, rst_n, cyc, stb, we, ack, err, dcoff, spin, ssh, spos, sneg, dcon, e;
    logic [7:0]  adr;
    logic [3:0]  sel, dcode;
    logic [31:0] wd, rd, q;
    logic [9:0]  ph;
    logic [1:0]  isel;
    logic [23:0] off, gain;
    int          mismatches, check_count, i;
    // Address, write data, expected readback
    logic [39:0] rows [6] = '{40'h38FFFFFFC7, 40'h3CA5C3A5C3, 40'h405AFF5A00,
                              40'h4412341234, 40'h488E7F8E00, 40'h0C00F50005};
    chan_one_config_cal_regs u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wd),
        .O_WB_DAT(rd), .O_WB_ACK(ack), .O_WB_ERR(err), .O_CHAN_ONE_PHASE_DELAY(ph),
        .O_CHAN_ONE_DC_BLOCK_OFF(dcoff), .O_CHAN_ONE_INPUT_SELECT(isel), .O_SEL_PINS(spin),
        .O_SEL_SHORTED(ssh), .O_SEL_TEST_POS(spos), .O_SEL_TEST_NEG(sneg),
        .O_CHAN_ONE_OFFSET(off), .O_CHAN_ONE_GAIN(gain), .O_DC_FILTER_CODE(dcode),
        .O_DC_FILTER_ON(dcon));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask
    // Single classic cycle; holds the request until ack or err
    task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= 4'hF;
        wd  <= {16'h0000, d};
        do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
        q = rd;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        end_sim;
    end
    initial begin
        {rst_n, cyc, stb, we, adr, sel, wd} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        chk("gain out", 32'h800000, gain);
        chk("pins", 32'h1, {sneg, spos, ssh, spin});
        wb(1'b0, 8'h44, 16'h0000);
        chk("gain upper", 32'h8000, q);
        wb(1'b0, 8'h38, 16'h0000);
        chk("config", 32'h0, q);
        $display("test reset done");
        for (i = 0; i < 6; i++) begin
            wb(1'b1, rows[i][39:32], rows[i][31:16]);
            wb(1'b0, rows[i][39:32], 16'h0000);
            chk("readback", {16'h0000, rows[i][15:0]}, q);
        end
        settle;
        chk("phase", 32'h3FF, ph);
        chk("offset", 32'hA5C35A, off);
        chk("gain", 32'h12348E, gain);
        chk("dc code", 32'h0, dcode);
        chk("dc off", 32'h1, dcoff);
        $display("test rows done");
        for (i = 0; i < 4; i++) begin
            wb(1'b1, 8'h38, 16'(i));
            settle;
            chk("select", i, isel);
            chk("one hot", 32'h1 << i, {sneg, spos, ssh, spin});
            chk("dc code", 32'h5, dcode);
            chk("dc on", 32'h1, dcon);
        end
        wb(1'b1, 8'h0C, 16'h0000);
        settle;
        chk("dc on", 32'h0, dcon);
        $display("test select done");
        wb(1'b0, 8'h4C, 16'h0000);
        chk("unmapped", 32'h1, e);
        wb(1'b1, 8'h3D, 16'h1234);
        chk("misaligned", 32'h1, e);
        wb(1'b0, 8'h3C, 16'h0000);
        chk("offset kept", 32'hA5C3, q);
        @(posedge clk);
        rst_n <= 1'b0;
        settle;
        chk("gain again", 32'h800000, gain);
        @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, 8'h3C, 16'h0000);
        chk("offset reset", 32'h0, q);
        $display("test errors done");
        end_sim;
    end
endmodule
bind chan_one_config_cal_regs chan_one_regs_sva u_sva (.*);

// File: sim/chan_one_regs_sva.sv
/* Assertion checker for the channel one register bank.
   Assumes binding to the bank top module, port names as there. */
`timescale 1ns/1ps
module chan_one_regs_sva (
    // Clock and bus
    input wire        I_CLK,
    input wire        I_RST_N,
    input wire        I_WB_CYC,
    input wire        I_WB_STB,
    input wire        I_WB_WE,
    input wire [7:0]  I_WB_ADR,
    input wire [3:0]  I_WB_SEL,
    input wire [31:0] I_WB_DAT,
    input wire [31:0] O_WB_DAT,
    input wire        O_WB_ACK,
    input wire        O_WB_ERR,
    // Channel controls
    input wire [9:0]  O_CHAN_ONE_PHASE_DELAY,
    input wire        O_CHAN_ONE_DC_BLOCK_OFF,
    input wire [1:0]  O_CHAN_ONE_INPUT_SELECT,
    input wire        O_SEL_PINS,
    input wire        O_SEL_SHORTED,
    input wire        O_SEL_TEST_POS,
    input wire        O_SEL_TEST_NEG,
    input wire [23:0] O_CHAN_ONE_OFFSET,
    input wire [23:0] O_CHAN_ONE_GAIN,
    input wire [3:0]  O_DC_FILTER_CODE,
    input wire        O_DC_FILTER_ON
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    wire req = I_WB_CYC & I_WB_STB & !O_WB_ACK & !O_WB_ERR;
    wire wr  = O_WB_ACK & I_WB_WE & (I_WB_SEL == 4'hF);
    wire rd  = O_WB_ACK & !I_WB_WE;
    bus_answer_a: assert property (req |=> O_WB_ACK || O_WB_ERR)
        else $error("request not answered");
    unmapped_err_a: assert property (req && I_WB_ADR == 8'h4C |=> O_WB_ERR && !O_WB_ACK)
        else $error("unmapped access not refused");
    phase_load_a: assert property (wr && I_WB_ADR == 8'h38 |=> ##1
        O_CHAN_ONE_PHASE_DELAY == $past(I_WB_DAT[15:6], 2)) else $error("phase not loaded");
    dc_off_a: assert property (O_CHAN_ONE_DC_BLOCK_OFF |-> !O_DC_FILTER_ON)
        else $error("filter on while channel off");
    sel_own_a: assert property (O_SEL_PINS == (O_CHAN_ONE_INPUT_SELECT == 2'h0)
        && O_SEL_SHORTED == (O_CHAN_ONE_INPUT_SELECT == 2'h1)) else $error("pin decode");
    sel_test_a: assert property (O_SEL_TEST_POS == (O_CHAN_ONE_INPUT_SELECT == 2'h2)
        && O_SEL_TEST_NEG == (O_CHAN_ONE_INPUT_SELECT == 2'h3)) else $error("test decode");
    offset_load_a: assert property (wr && I_WB_ADR == 8'h3C |=> ##1
        O_CHAN_ONE_OFFSET[23:8] == $past(I_WB_DAT[15:0], 2)) else $error("offset not loaded");
    gain_low_a: assert property (wr && I_WB_ADR == 8'h48 |=> ##1
        O_CHAN_ONE_GAIN[7:0] == $past(I_WB_DAT[15:8], 2)) else $error("gain low not loaded");
    offset_low_a: assert property (wr && I_WB_ADR == 8'h40 |=> ##1
        O_CHAN_ONE_OFFSET[7:0] == $past(I_WB_DAT[15:8], 2)) else $error("offset low not loaded");
    gain_up_a: assert property (wr && I_WB_ADR == 8'h44 |=> ##1
        O_CHAN_ONE_GAIN[23:8] == $past(I_WB_DAT[15:0], 2)) else $error("gain upper not loaded");
    lower_rsvd_a: assert property (rd && (I_WB_ADR == 8'h40 || I_WB_ADR == 8'h48) |->
        O_WB_DAT[7:0] == 8'h00) else $error("lower reserved bits not zero");
    cfg_rsvd_a: assert property (rd && I_WB_ADR == 8'h38 |-> O_WB_DAT[5:3] == 3'h0)
        else $error("config reserved bits not zero");
    dc_on_a: assert property (O_DC_FILTER_ON == (O_DC_FILTER_CODE != 4'h0))
        else $error("filter enable and code disagree");
endmodule
